// *** verilog/rail_fault_sequencer_defines.svh ***
// Purpose: constants of the rail fault sequencer
// Assumes: APB word registers, 10 MHz pclk
// Notes: offsets are byte addresses
`ifndef RAIL_FAULT_SEQUENCER_DEFINES_SVH
`define RAIL_FAULT_SEQUENCER_DEFINES_SVH
`define A_CTRL 12'h000
`define A_CFG 12'h004
`define A_OT_LIM 12'h008
`define A_TEMP 12'h00C
`define A_STATUS 12'h010
`define A_TON_DLY 12'h014
`define A_TON_RISE 12'h018
`define A_TOFF_DLY 12'h01C
`define A_TOFF_FALL 12'h020
`define A_LIN_TGT 12'h024
`define A_LIN_MARGIN 12'h028
`define A_LIN_LIM 12'h02C
`define A_LIN_MEAS 12'h030
`define A_CUR_C 12'h034
`define A_CUR_D 12'h038
`define A_CUR_SUM 12'h03C
`define A_OC_LIM 12'h040
`define A_OC_CD 12'h044
`define A_CMD 12'h048
`define RST_DELAY 16'hF800
`define RST_RAMP 16'hF004
`define RST_OT_FAULT 10'h1F4
`define RST_OT_WARN 10'h1E0
`define RST_LIN_TGT 8'h20
`define TICK_US 1
`define TICK_CYC ((`TICK_US * 10))
`define MARGIN_MAX_PCT 15
`endif

// *** verilog/rail_fault_sequencer_pkg.sv ***
// Purpose: types of the rail fault sequencer
// Assumes: used through scoped names
// Notes: none
package rail_fault_sequencer_pkg;
  typedef enum logic [1:0] {OT_IGNORE, OT_LATCH, OT_RESTART} ot_resp_t;
  typedef enum logic [2:0] {R_OFF, R_DELAY, R_RISE, R_ON, R_OFFDLY, R_FALL} rail_st_t;
  typedef enum logic [1:0] {P_LOAD, P_RUN, P_SLEEP} pwr_st_t;
endpackage

// *** verilog/rail_fault_sequencer.sv ***
// Purpose: supervisory sequencing and fault logic of a five-rail power unit
// Assumes: rail 0..3 switchers A..D, rail 4 linear; sensors digitised upstream
// Notes: sequencing counts are 1 us ticks from the low 11 bits of each setting
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rail_fault_sequencer_defines.svh"
module rail_fault_sequencer #(
  parameter int NRAIL = 5,
  parameter int TW = 10,
  parameter int LOAD_CYC = 16
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [NRAIL-1:0] rail_en_pin,
  input wire logic sleep_n_pin,
  // nonvolatile straps
  input wire logic global_fault_en,
  input wire logic sleep_en,
  input wire logic combine_cd,
  input wire logic track_sel,
  // sensors
  input wire logic [TW-1:0] temp_ab,
  input wire logic [TW-1:0] temp_cdl,
  input wire logic [9:0] lin_out_adc,
  input wire logic [9:0] lin_in_adc,
  input wire logic [15:0] cur_c,
  input wire logic [15:0] cur_d,
  input wire logic [15:0] vin_c,
  // host command screening
  input wire logic [2:0] cmd_rail,
  input wire logic cmd_valid,
  output logic cmd_nack,
  // rails
  output logic [NRAIL-1:0] rail_on,
  output logic [NRAIL-1:0] rail_ramp,
  output logic pwm_d_from_c,
  output logic d_antiphase,
  output logic lin_track,
  output logic [9:0] lin_ref,
  output logic nvm_load
);
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmd_nack;
    logic [NRAIL-1:0] op;
    logic [1:0] ot_resp;
    logic [1:0] lin_resp;
    logic [TW-1:0] ot_fault;
    logic [TW-1:0] ot_warn;
    logic [15:0] ton_dly;
    logic [15:0] ton_rise;
    logic [15:0] toff_dly;
    logic [15:0] toff_fall;
    logic [7:0] lin_tgt;
    logic [4:0] margin;
    logic margin_dn;
    logic [15:0] oc_lim;
    logic [15:0] cur_cal;
    logic [NRAIL-1:0] latched;
    logic [NRAIL-1:0] en_prev;
    logic [NRAIL-1:0] op_prev;
    logic [3:0] warn;
    logic [NRAIL-1:0][2:0] st;
    logic [NRAIL-1:0][10:0] cnt;
    logic [3:0] tick_cnt;
    logic tick;
    logic [2:0] slp_sync;
    logic [NRAIL-1:0][2:0] en_sync;
    logic [NRAIL-1:0] en;
    logic slp;
    logic [1:0] pwr;
    logic [7:0] load_cnt;
    logic [NRAIL-1:0] on;
    logic [NRAIL-1:0] ramp;
    logic [9:0] ref_q;
    logic pwm_cd;
    logic track;
    logic load;
  } state_t;
  state_t s_q, s_d;
  logic wr, rd;
  logic [TW-1:0] temp_rail [NRAIL];
  logic [9:0] lin_base;
  logic [11:0] lim_ov, lim_uv, lim_ovw, lim_uvw;
  logic [16:0] cur_sum;
  logic [NRAIL-1:0] ot_hit, lin_hit, fault_stop;
  logic any_stop;
  logic [6:0] margin_pct;
  logic [16:0] ref_prod;
  logic wr_err;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign wr_err = psel && !penable && pwrite && (paddr > `A_CMD || paddr[1:0] != 2'b00);
  assign temp_rail[0] = temp_ab;
  assign temp_rail[1] = temp_ab;
  assign temp_rail[2] = temp_cdl;
  assign temp_rail[3] = temp_cdl;
  assign temp_rail[4] = temp_cdl;
  // target in 1/64 V, tracking uses half input
  assign lin_base = track_sel ? {1'b0, lin_in_adc[9:1]} : {s_q.lin_tgt, 2'b00};
  assign lim_ov = 12'(lin_base) + 12'(lin_base >> 2);
  assign lim_uv = 12'(lin_base) - 12'(lin_base >> 2);
  assign lim_ovw = 12'(lin_base) + 12'(lin_base >> 3);
  assign lim_uvw = 12'(lin_base) - 12'(lin_base >> 3);
  // summed current with calibration on the sum
  assign cur_sum = 17'(cur_c) + 17'(cur_d) + 17'(s_q.cur_cal);
  // percentage of the base, down or up
  assign margin_pct = s_q.margin_dn ? 7'd100 - 7'(s_q.margin) : 7'd100 + 7'(s_q.margin);
  assign ref_prod = 17'(lin_base) * 17'(margin_pct);
  genvar g;
  generate
    for (g = 0; g < NRAIL; g++) begin : g_flt
      assign ot_hit[g] = temp_rail[g] > s_q.ot_fault;
      if (g == NRAIL - 1) begin : g_lin
        // digital compare, ignore or shutdown
        // each limit has its own response bit
        assign lin_hit[g] = s_q.on[g] && !s_q.ramp[g] &&
          ((s_q.lin_resp[0] && 12'(lin_out_adc) > lim_ov) ||
          (s_q.lin_resp[1] && 12'(lin_out_adc) < lim_uv));
      end else begin : g_sw
        assign lin_hit[g] = 1'b0;
      end
      assign fault_stop[g] = lin_hit[g] || (ot_hit[g] && s_q.ot_resp != 2'(rail_fault_sequencer_pkg::OT_IGNORE));
    end
  endgenerate
  assign any_stop = |fault_stop;
  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b1;
    s_d.pslverr = 1'b0;
    // one-cycle enable each microsecond; all sequencing counts run on it
    s_d.tick = 1'b0;
    s_d.tick_cnt = s_q.tick_cnt + 4'h1;
    if (s_q.tick_cnt == 4'(`TICK_CYC - 1)) begin
      s_d.tick_cnt = 4'h0;
      s_d.tick = 1'b1;
    end
    s_d.slp_sync = {s_q.slp_sync[1:0], sleep_n_pin};
    // a pin level counts once the last two flops agree
    if (s_q.slp_sync[2] == s_q.slp_sync[1]) begin
      s_d.slp = !s_q.slp_sync[2];
    end
    for (int i = 0; i < NRAIL; i++) begin
      s_d.en_sync[i] = {s_q.en_sync[i][1:0], rail_en_pin[i]};
      if (s_q.en_sync[i][2] == s_q.en_sync[i][1]) begin
        s_d.en[i] = s_q.en_sync[i][2];
      end
    end
    s_d.en_prev = s_q.en;
    s_d.op_prev = s_q.op;
    s_d.warn = {12'(lin_out_adc) > lim_ovw || 12'(lin_out_adc) < lim_uvw,
      temp_cdl > s_q.ot_warn, 1'b0, temp_ab > s_q.ot_warn};
    s_d.cmd_nack = cmd_valid && combine_cd && cmd_rail == 3'd3;
    if (rd) begin
      case (paddr)
        `A_CTRL: s_d.prdata = 32'(s_q.op);
        `A_CFG: s_d.prdata = {26'h0, s_q.lin_resp, s_q.ot_resp, 2'h0};
        `A_OT_LIM: s_d.prdata = {6'h0, s_q.ot_warn, 6'h0, s_q.ot_fault};
        `A_TEMP: s_d.prdata = {6'h0, temp_cdl, 6'h0, temp_ab};
        `A_STATUS: s_d.prdata = {11'h0, s_q.warn, s_q.latched,
          1'b0, s_q.ramp, 1'b0, s_q.on};
        `A_TON_DLY: s_d.prdata = {16'h0, s_q.ton_dly};
        `A_TON_RISE: s_d.prdata = {16'h0, s_q.ton_rise};
        `A_TOFF_DLY: s_d.prdata = {16'h0, s_q.toff_dly};
        `A_TOFF_FALL: s_d.prdata = {16'h0, s_q.toff_fall};
        `A_LIN_TGT: s_d.prdata = {24'h0, s_q.lin_tgt};
        `A_LIN_MARGIN: s_d.prdata = {26'h0, s_q.margin_dn, s_q.margin};
        `A_LIN_LIM: s_d.prdata = {lim_uv[7:0], lim_uvw[7:0], lim_ovw[7:0], lim_ov[7:0]};
        `A_LIN_MEAS: s_d.prdata = {22'h0, lin_out_adc};
        `A_CUR_C: s_d.prdata = combine_cd ? {15'h0, cur_sum} : {16'h0, cur_c};
        `A_CUR_D: s_d.prdata = {16'h0, vin_c};
        `A_CUR_SUM: s_d.prdata = {15'h0, cur_sum};
        `A_OC_LIM: s_d.prdata = {16'h0, s_q.oc_lim};
        `A_OC_CD: s_d.prdata = combine_cd ? {1'b0, s_q.oc_lim[15:1], 1'b0, s_q.oc_lim[15:1]} : {16'h0, s_q.oc_lim};
        `A_CMD: s_d.prdata = {31'h0, combine_cd};
        default: begin
          s_d.prdata = 32'h0;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    // write errors flagged at setup so they stand in the access cycle
    if (wr_err) begin
      s_d.pslverr = 1'b1;
    end
    if (wr) begin
      case (paddr)
        `A_CTRL: s_d.op = pwdata[NRAIL-1:0];
        `A_CFG: begin
          s_d.ot_resp = pwdata[3:2];
          s_d.lin_resp = pwdata[5:4];
        end
        `A_OT_LIM: begin
          s_d.ot_fault = pwdata[TW-1:0];
          s_d.ot_warn = pwdata[16+TW-1:16];
        end
        `A_TON_DLY: s_d.ton_dly = pwdata[15:0];
        `A_TON_RISE: s_d.ton_rise = pwdata[15:0];
        `A_TOFF_DLY: s_d.toff_dly = pwdata[15:0];
        `A_TOFF_FALL: s_d.toff_fall = pwdata[15:0];
        `A_LIN_TGT: s_d.lin_tgt = pwdata[7:0];
        `A_LIN_MARGIN: begin
          s_d.margin = (pwdata[4:0] > 5'(`MARGIN_MAX_PCT)) ? 5'(`MARGIN_MAX_PCT) : pwdata[4:0];
          s_d.margin_dn = pwdata[5];
        end
        // halved per switcher in combined mode
        `A_OC_LIM: s_d.oc_lim = pwdata[15:0];
        `A_CUR_SUM: s_d.cur_cal = pwdata[15:0];
        `A_LIN_LIM, `A_TEMP, `A_STATUS, `A_LIN_MEAS, `A_CUR_C, `A_CUR_D, `A_OC_CD, `A_CMD: ;
        default: ;
      endcase
    end
    s_d.ref_q = 10'(ref_prod / 17'd100);
    for (int i = 0; i < NRAIL; i++) begin
      // cleared before the set below, so a set in the same cycle wins
      // enable or operation cycle clears latch
      if ((s_q.en_prev[i] && !s_q.en[i]) || (s_q.op_prev[i] && !s_q.op[i])) begin
        s_d.latched[i] = 1'b0;
      end
      // a global stop latches every rail not in R_OFF; only a cycle restarts them
      // global or local stop
      if ((global_fault_en ? any_stop : fault_stop[i]) && s_q.st[i] != 3'(rail_fault_sequencer_pkg::R_OFF)) begin
        if (s_q.ot_resp == 2'(rail_fault_sequencer_pkg::OT_LATCH) || lin_hit[i] || global_fault_en) begin
          s_d.latched[i] = 1'b1;
        end
        s_d.st[i] = 3'(rail_fault_sequencer_pkg::R_OFF);
        s_d.on[i] = 1'b0;
        s_d.ramp[i] = 1'b0;
      end else if (s_q.tick) begin
        case (s_q.st[i])
          3'(rail_fault_sequencer_pkg::R_OFF): if (s_q.en[i] && s_q.op[i] && !s_q.latched[i] && !fault_stop[i]
              && s_q.pwr == 2'(rail_fault_sequencer_pkg::P_RUN) && !(combine_cd && i == 3)) begin
            s_d.st[i] = 3'(rail_fault_sequencer_pkg::R_DELAY);
            s_d.cnt[i] = s_q.ton_dly[10:0];
          end
          3'(rail_fault_sequencer_pkg::R_DELAY): if (s_q.cnt[i] == 11'h0) begin
            s_d.on[i] = 1'b1;
            s_d.ramp[i] = (i != NRAIL - 1);
            s_d.st[i] = (i == NRAIL - 1) ? 3'(rail_fault_sequencer_pkg::R_ON) : 3'(rail_fault_sequencer_pkg::R_RISE);
            s_d.cnt[i] = s_q.ton_rise[10:0];
          end else s_d.cnt[i] = s_q.cnt[i] - 11'h1;
          3'(rail_fault_sequencer_pkg::R_RISE): if (s_q.cnt[i] == 11'h0) begin
            s_d.ramp[i] = 1'b0;
            s_d.st[i] = 3'(rail_fault_sequencer_pkg::R_ON);
          end else s_d.cnt[i] = s_q.cnt[i] - 11'h1;
          3'(rail_fault_sequencer_pkg::R_ON): if (!s_q.en[i] || !s_q.op[i]) begin
            s_d.st[i] = (i == NRAIL - 1) ? 3'(rail_fault_sequencer_pkg::R_OFF) : 3'(rail_fault_sequencer_pkg::R_OFFDLY);
            s_d.on[i] = (i != NRAIL - 1);
            s_d.cnt[i] = s_q.toff_dly[10:0];
          end
          3'(rail_fault_sequencer_pkg::R_OFFDLY): if (s_q.cnt[i] == 11'h0) begin
            s_d.ramp[i] = 1'b1;
            s_d.st[i] = 3'(rail_fault_sequencer_pkg::R_FALL);
            s_d.cnt[i] = s_q.toff_fall[10:0];
          end else s_d.cnt[i] = s_q.cnt[i] - 11'h1;
          3'(rail_fault_sequencer_pkg::R_FALL): if (s_q.cnt[i] == 11'h0) begin
            s_d.ramp[i] = 1'b0;
            s_d.on[i] = 1'b0;
            s_d.st[i] = 3'(rail_fault_sequencer_pkg::R_OFF);
          end else s_d.cnt[i] = s_q.cnt[i] - 11'h1;
          default: s_d.st[i] = 3'(rail_fault_sequencer_pkg::R_OFF);
        endcase
      end
    end
    case (s_q.pwr)
      2'(rail_fault_sequencer_pkg::P_LOAD): begin
        // fixed count stands in for the nonvolatile copy
        // full reload before running
        s_d.load_cnt = s_q.load_cnt + 8'h1;
        if (s_q.load_cnt == 8'(LOAD_CYC)) s_d.pwr = 2'(rail_fault_sequencer_pkg::P_RUN);
      end
      2'(rail_fault_sequencer_pkg::P_RUN): if (sleep_en && s_q.slp) s_d.pwr = 2'(rail_fault_sequencer_pkg::P_SLEEP);
      2'(rail_fault_sequencer_pkg::P_SLEEP): if (!s_q.slp) begin
        s_d.pwr = 2'(rail_fault_sequencer_pkg::P_LOAD);
        s_d.load_cnt = 8'h0;
      end
      default: s_d.pwr = 2'(rail_fault_sequencer_pkg::P_LOAD);
    endcase
    // straps and the sleep pin filter survive, all else restarts
    // sleep forces reset of volatile state
    if (s_q.pwr == 2'(rail_fault_sequencer_pkg::P_SLEEP)) begin
      s_d = '0;
      s_d.pwr = s_q.pwr;
      s_d.slp = (s_q.slp_sync[2] == s_q.slp_sync[1]) ? !s_q.slp_sync[2] : s_q.slp;
      s_d.slp_sync = {s_q.slp_sync[1:0], sleep_n_pin};
      s_d.pready = 1'b1;
      s_d.pslverr = psel;
      s_d.ton_dly = `RST_DELAY;
      s_d.ton_rise = `RST_RAMP;
      s_d.toff_dly = `RST_DELAY;
      s_d.toff_fall = `RST_RAMP;
      s_d.ot_fault = `RST_OT_FAULT;
      s_d.ot_warn = `RST_OT_WARN;
      s_d.lin_tgt = `RST_LIN_TGT;
      s_d.ot_resp = 2'(rail_fault_sequencer_pkg::OT_LATCH);
      if (!s_q.slp) begin
        s_d.pwr = 2'(rail_fault_sequencer_pkg::P_LOAD);
      end
    end
    // outputs taken from the next state keep their timing but leave a flop
    s_d.pwm_cd = !s_d.latched[2] && s_d.pwr == 2'(rail_fault_sequencer_pkg::P_RUN) && combine_cd;
    s_d.track = track_sel;
    s_d.load = s_d.pwr == 2'(rail_fault_sequencer_pkg::P_LOAD);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.pready <= 1'b1;
      s_q.load <= 1'b1;
      s_q.ton_dly <= `RST_DELAY;
      s_q.ton_rise <= `RST_RAMP;
      s_q.toff_dly <= `RST_DELAY;
      s_q.toff_fall <= `RST_RAMP;
      s_q.ot_fault <= `RST_OT_FAULT;
      s_q.ot_warn <= `RST_OT_WARN;
      s_q.lin_tgt <= `RST_LIN_TGT;
      s_q.ot_resp <= 2'(rail_fault_sequencer_pkg::OT_LATCH);
    end else begin
      s_q <= s_d;
    end
  end
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign cmd_nack = s_q.cmd_nack;
  assign rail_on = s_q.on;
  assign rail_ramp = s_q.ramp;
  assign pwm_d_from_c = s_q.pwm_cd;
  assign d_antiphase = s_q.pwm_cd;
  assign lin_track = s_q.track;
  assign lin_ref = s_q.ref_q;
  assign nvm_load = s_q.load;
endmodule
`default_nettype wire

// *** verification/rail_fault_sequencer_props.sv ***
// Purpose: port properties of the rail fault sequencer
// Assumes: straps steady between resets
// Notes: bound at the foot
`timescale 1ns/1ns
`default_nettype none
module rail_fault_sequencer_props #(
  parameter int NRAIL = 5
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // pins, straps, commands, rails
  input wire logic sleep_n_pin,
  input wire logic sleep_en,
  input wire logic combine_cd,
  input wire logic [2:0] cmd_rail,
  input wire logic cmd_valid,
  input wire logic cmd_nack,
  input wire logic [NRAIL-1:0] rail_on,
  input wire logic nvm_load
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_always_a: assert property (pready)
    else $error("pready low");
  unmapped_err_a: assert property (psel && penable && paddr > 12'h048 |-> pslverr)
    else $error("unmapped access accepted");
  nack_on_d_a: assert property (cmd_valid && cmd_rail == 3'h3 && combine_cd && !nvm_load |=> cmd_nack)
    else $error("switcher D command accepted");
  nack_cause_a: assert property (cmd_nack |-> $past(cmd_valid) && $past(cmd_rail) == 3'h3 && combine_cd)
    else $error("refusal without cause");
  sleep_off_a: assert property ($fell(sleep_n_pin) && sleep_en |-> ##[1:8] rail_on == '0)
    else $error("rails alive in sleep");
  sleep_mute_a: assert property ((sleep_en && !sleep_n_pin)[*8] ##0 psel && penable |-> pslverr)
    else $error("access served in sleep");
  wake_load_a: assert property ($rose(sleep_n_pin) && sleep_en |-> ##[1:8] nvm_load)
    else $error("no reload after sleep");
  load_quiet_a: assert property (nvm_load |-> rail_on == '0)
    else $error("rail on during reload");
  cover property (cmd_nack);
  cover property ($rose(sleep_n_pin) ##[1:8] nvm_load);
  cover property (psel && penable && pslverr);
endmodule
bind rail_fault_sequencer rail_fault_sequencer_props #(.NRAIL(NRAIL)) u_props (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .sleep_n_pin, .sleep_en, .combine_cd, .cmd_rail, .cmd_valid, .cmd_nack, .rail_on,
  .nvm_load);
`default_nettype wire

// *** verification/pmbus_host_model.sv ***
// Purpose: host model for register bus and command screening
// Assumes: requests launched just after a rising edge
// Notes: hang rises when an answer never comes
`timescale 1ns/1ns
`default_nettype none
module pmbus_host_model (
  // clock
  input wire logic pclk,
  // apb
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // commands
  output logic [2:0] cmd_rail,
  output logic cmd_valid,
  output logic hang
);
  initial begin
    {psel, penable, pwrite, cmd_valid, hang} = 5'h00;
    {paddr, pwdata, cmd_rail} = 47'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look half a cycle ahead so the answer is read as the edge sees it
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    q = prdata;
    e = pslverr;
    @(posedge pclk);
    hang <= (n == 20);
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not look like a held value
    pwdata <= ~d;
  endtask
  task automatic cmd(input logic [2:0] r);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_rail <= r;
    @(posedge pclk);
    cmd_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verification/test_rail_fault_sequencer.sv ***
// Purpose: self-checking bench of the rail fault sequencer
// Assumes: global and combined modes chosen at reset
// Notes: sequencing ticks are 10 cycles
`timescale 1ns/1ns
`default_nettype none
module test_rail_fault_sequencer;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_n_pin, global_fault_en, sleep_en, e;
  logic combine_cd, track_sel, cmd_valid, cmd_nack, hang, pwm_d_from_c, d_antiphase, lin_track, nvm_load;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] rail_en_pin, rail_on, rail_ramp;
  logic [9:0] temp_ab, temp_cdl, lin_out_adc, lin_in_adc, lin_ref;
  logic [15:0] cur_c, cur_d, vin_c;
  logic [2:0] cmd_rail;
  int err_count, comparisons;
  rail_fault_sequencer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rail_en_pin, .sleep_n_pin, .global_fault_en, .sleep_en, .combine_cd, .track_sel, .temp_ab, .temp_cdl,
    .lin_out_adc, .lin_in_adc, .cur_c, .cur_d, .vin_c, .cmd_rail, .cmd_valid, .cmd_nack, .rail_on, .rail_ramp,
    .pwm_d_from_c, .d_antiphase, .lin_track, .lin_ref, .nvm_load);
  pmbus_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_rail,
    .cmd_valid, .hang);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge hang) begin
    err_count++;
    final_report();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task rw(input logic w, input logic [11:0] a, input logic [31:0] d);
    host.xfer(w, a, d, q, e);
  endtask
  // s picks reload flag instead of rails
  task automatic wt(input logic s, input logic [4:0] v);
    int n;
    n = 0;
    while ((s ? {4'h0, nvm_load} : rail_on) !== v && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk({27'h0, s ? {4'h0, nvm_load} : rail_on}, {27'h0, v});
    if (n == 400)
      final_report();
  endtask
  task rst(input logic g, input logic c);
    @(posedge pclk);
    global_fault_en <= g;
    combine_cd <= c;
    lin_out_adc <= 10'h2A5;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rw(1'b1, 12'h004, 32'h4);
    rw(1'b1, 12'h000, 32'h1F);
    wt(1'b0, c ? 5'h17 : 5'h1F);
    chk({27'h0, rail_ramp}, c ? 32'h07 : 32'h0F);
  endtask
  task t_regs;
    rw(1'b0, 12'h008, 32'h0);
    chk(q, 32'h01E0_01F4);
    for (int a = 20; a <= 32; a += 4) begin
      rw(1'b0, 12'(a), 32'h0);
      chk(q, a[2] ? 32'hF800 : 32'hF004);
    end
    rw(1'b0, 12'h024, 32'h0);
    chk(q, 32'h20);
    rw(1'b0, 12'h030, 32'h0);
    chk(q, 32'h2A5);
    rw(1'b1, 12'h02C, 32'hFFFF_FFFF);
    rw(1'b0, 12'h02C, 32'h0);
    chk(q, 32'h6070_90A0);
    rw(1'b0, 12'h00C, 32'h0);
    chk(q, 32'h0100_0100);
    rw(1'b1, 12'h028, 32'h14);
    rw(1'b0, 12'h028, 32'h0);
    chk(q, 32'hF);
    rw(1'b0, 12'h04C, 32'h0);
    chk({31'h0, e}, 32'h1);
    track_sel <= 1'b1;
    @(posedge pclk);
    #1 chk({31'h0, lin_track}, 32'h1);
    chk({22'h0, lin_ref}, 32'h126);
  endtask
  task t_ot;
    temp_ab <= 10'h1F4;
    repeat (30) @(posedge pclk);
    chk({27'h0, rail_on}, 32'h1F);
    rw(1'b0, 12'h010, 32'h0);
    chk(q, 32'h0012_001F);
    temp_ab <= 10'h1F5;
    wt(1'b0, 5'h1C);
    temp_ab <= 10'h100;
    repeat (30) @(posedge pclk);
    chk({27'h0, rail_on}, 32'h1C);
    rail_en_pin <= 5'h1C;
    repeat (10) @(posedge pclk);
    rail_en_pin <= 5'h1F;
    wt(1'b0, 5'h1F);
    rw(1'b1, 12'h004, 32'h8);
    temp_cdl <= 10'h1F5;
    wt(1'b0, 5'h03);
    temp_cdl <= 10'h100;
    wt(1'b0, 5'h1F);
    rw(1'b1, 12'h004, 32'h20);
    lin_out_adc <= 10'h000;
    wt(1'b0, 5'h0F);
  endtask
  task t_global;
    rst(1'b1, 1'b0);
    temp_ab <= 10'h1F5;
    wt(1'b0, 5'h00);
    temp_ab <= 10'h100;
  endtask
  task t_comb;
    rst(1'b0, 1'b1);
    #1 chk({30'h0, pwm_d_from_c, d_antiphase}, 32'h3);
    host.cmd(3'h3);
    #1 chk({31'h0, cmd_nack}, 32'h1);
    host.cmd(3'h2);
    #1 chk({31'h0, cmd_nack}, 32'h0);
    rw(1'b0, 12'h034, 32'h0);
    chk(q, 32'h120);
    rw(1'b1, 12'h03C, 32'h5);
    rw(1'b0, 12'h034, 32'h0);
    chk(q, 32'h125);
    rw(1'b1, 12'h040, 32'h200);
    rw(1'b0, 12'h044, 32'h0);
    chk({16'h0, q[15:0]}, 32'h100);
    rw(1'b0, 12'h038, 32'h0);
    chk({16'h0, q[15:0]}, 32'h1234);
  endtask
  task t_sleep;
    rw(1'b1, 12'h008, 32'h0100_0150);
    sleep_n_pin <= 1'b0;
    wt(1'b0, 5'h00);
    repeat (4) @(posedge pclk);
    rw(1'b0, 12'h008, 32'h0);
    chk({31'h0, e}, 32'h1);
    sleep_n_pin <= 1'b1;
    wt(1'b1, 5'h01);
    wt(1'b1, 5'h00);
    rw(1'b0, 12'h008, 32'h0);
    chk(q, 32'h01E0_01F4);
  endtask
  initial begin
    {presetn, global_fault_en, combine_cd, track_sel} = 4'h0;
    {rail_en_pin, sleep_n_pin, sleep_en} = 7'h7F;
    {temp_ab, temp_cdl, lin_out_adc, lin_in_adc} = {10'h100, 10'h100, 10'h2A5, 10'h200};
    {cur_c, cur_d, vin_c} = {16'h0100, 16'h0020, 16'h1234};
    err_count = 0;
    comparisons = 0;
    rst(1'b0, 1'b0);
    t_regs();
    t_ot();
    t_global();
    t_comb();
    t_sleep();
    final_report();
  end
endmodule
`default_nettype wire
